// file: rtl/spsq_pkg.sv
// shared constants and types for the stepper phase sequencer
package spsq_pkg;

    localparam int unsigned CLK_HZ = 40_000_000;
    localparam real STEP_PERIOD_MS = 2.5;
    localparam int unsigned STEP_CYCLES =
        int'(STEP_PERIOD_MS * real'(CLK_HZ) / 1000.0);
    // clear width that the outside world guarantees; not counted here
    localparam real CLEAR_WIDTH_MS = 1.0;

    localparam int unsigned STAGES = 8;
    localparam int unsigned PHASES = 4;
    localparam int unsigned STEPS_PER_REV = 64;
    localparam int unsigned STEP_ANGLE_MDEG = 5625;
    localparam int unsigned REV_W = $clog2(STEPS_PER_REV);
    localparam logic [REV_W-1:0] REV_LAST = REV_W'(STEPS_PER_REV - 1);
    localparam logic [STAGES-1:0] STAGES_CLEAR = 8'h00;
    localparam logic [STAGES-1:0] SEED_BIT = 8'h01;

    typedef enum logic [2:0] {
        MODE_WAVE   = 3'h1,
        MODE_NORMAL = 3'h2,
        MODE_HALF   = 3'h4
    } spsq_mode_t;

    typedef struct packed {
        logic [PHASES-1:0] phase_data;
        logic [PHASES-1:0] phase_enable;
    } spsq_phase_t;

endpackage : spsq_pkg

// file: rtl/spsq_step_div.sv
// divider that turns the core clock into a one-cycle step enable
`timescale 1ns/1ps
module spsq_step_div
    import spsq_pkg::*;
#(
    parameter int unsigned DIV = STEP_CYCLES
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // step enable
    output logic step_en_o
);

    localparam int unsigned CW = $clog2(DIV);
    localparam logic [CW-1:0] CNT_LAST = CW'(DIV - 1);
    localparam logic [CW-1:0] CNT_ZERO = '0;

    logic [CW-1:0] cnt_reg;

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_reg <= CNT_ZERO;
            step_en_o <= 1'b0;
        end else if (cnt_reg == CNT_LAST) begin
            cnt_reg <= CNT_ZERO;
            step_en_o <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + CW'(1);
            step_en_o <= 1'b0;
        end
    end

endmodule : spsq_step_div

// file: rtl/spsq_sequencer.sv
// eight-stage circulating phase sequencer for a bridge-driven stepper
`timescale 1ns/1ps
module spsq_sequencer
    import spsq_pkg::*;
#(
    parameter int unsigned STEP_DIV = STEP_CYCLES
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // pins from the board
    input wire logic power_up_clear_n_i,
    input wire logic dir_fwd_i,
    input wire logic [2:0] drive_mode_i,
    // half-bridge drive
    output spsq_phase_t phase_o,
    // status
    output logic [STAGES-1:0] stage_o,
    output logic step_o,
    output logic rev_o
);

    logic step_en;
    logic [1:0] clr_n_sync_reg;
    logic [1:0] dir_sync_reg;
    logic [2:0] mode_meta_reg;
    logic [2:0] mode_sync_reg;
    logic [STAGES-1:0] stage_reg;
    spsq_mode_t mode_reg;
    logic dir_reg;
    logic half_reg;
    logic [REV_W-1:0] rev_cnt_reg;
    logic clear_ok;
    logic right_serial_in;
    logic left_serial_in;
    logic shift_now;
    logic [STAGES-1:0] energise;

    spsq_step_div #(
        .DIV(STEP_DIV)
    ) u_div (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .step_en_o(step_en)
    );

    function automatic logic [STAGES-1:0] neighbour(
        input logic [STAGES-1:0] q,
        input logic fwd
    );
        neighbour = fwd ? {q[STAGES-2:0], q[STAGES-1]}
                        : {q[0], q[STAGES-1:1]};
    endfunction : neighbour

    // number of windings that a phase enable vector energises
    function automatic int unsigned count_on(
        input logic [PHASES-1:0] en
    );
        count_on = 0;
        for (int unsigned i = 0; i < PHASES; i++) begin
            count_on = count_on + 32'(en[i]);
        end
    endfunction : count_on

    // pin inputs pass two flops before anything reads them
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            clr_n_sync_reg <= 2'h0;
            dir_sync_reg <= 2'h0;
            mode_meta_reg <= 3'h0;
            mode_sync_reg <= 3'h0;
        end else begin
            clr_n_sync_reg <= {clr_n_sync_reg[0], power_up_clear_n_i};
            dir_sync_reg <= {dir_sync_reg[0], dir_fwd_i};
            mode_meta_reg <= drive_mode_i;
            mode_sync_reg <= mode_meta_reg;
        end
    end

    assign clear_ok = clr_n_sync_reg[1];

    // all-low detect feeds both serial inputs so the ring seeds itself
    assign right_serial_in = (stage_reg == STAGES_CLEAR)
                             | stage_reg[STAGES-1];
    assign left_serial_in = (stage_reg == STAGES_CLEAR)
                            | stage_reg[0];

    // in half-step the ring moves on every second step only, or on the next step when it is empty
    assign shift_now = step_en & clear_ok
                       & ((mode_reg != MODE_HALF) | half_reg
                          | (stage_reg == STAGES_CLEAR));

    // ring register: right shift moves toward stage eight
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stage_reg <= STAGES_CLEAR;
        end else if (!clear_ok) begin
            stage_reg <= STAGES_CLEAR;
        end else if (shift_now) begin
            if (dir_reg) begin
                stage_reg <= {stage_reg[STAGES-2:0],
                              right_serial_in};
            end else begin
                stage_reg <= {left_serial_in,
                              stage_reg[STAGES-1:1]};
            end
        end
    end

    // mode and direction change only at a step boundary, so the
    // outputs never show a mix of two patterns
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode_reg <= MODE_WAVE;
            dir_reg <= 1'b1;
        end else if (step_en) begin
            dir_reg <= dir_sync_reg[1];
            if (mode_sync_reg == MODE_WAVE
                || mode_sync_reg == MODE_NORMAL
                || mode_sync_reg == MODE_HALF) begin
                mode_reg <= spsq_mode_t'(mode_sync_reg);
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            half_reg <= 1'b0;
        end else if (!clear_ok) begin
            half_reg <= 1'b0;
        end else if (step_en) begin
            if (mode_reg == MODE_HALF) begin
                half_reg <= ~half_reg;
            end else begin
                half_reg <= 1'b0;
            end
        end
    end

    // positions 0-3 are windings A-D in one polarity, 4-7 reversed
    always_comb begin
        energise = stage_reg;
        if (mode_reg == MODE_NORMAL) begin
            energise = stage_reg | neighbour(stage_reg, dir_reg);
        end else if (mode_reg == MODE_HALF && half_reg) begin
            energise = stage_reg | neighbour(stage_reg, dir_reg);
        end
    end

    // one data and one enable per winding serve both half-bridges
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            phase_o <= '0;
            stage_o <= STAGES_CLEAR;
        end else begin
            phase_o.phase_data <= energise[PHASES-1:0];
            phase_o.phase_enable <= energise[PHASES-1:0]
                                    | energise[STAGES-1:PHASES];
            stage_o <= stage_reg;
        end
    end

    // revolution marker counts full ring steps
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rev_cnt_reg <= '0;
            rev_o <= 1'b0;
            step_o <= 1'b0;
        end else begin
            step_o <= shift_now;
            rev_o <= shift_now && (rev_cnt_reg == REV_LAST);
            if (!clear_ok) begin
                rev_cnt_reg <= '0;
            end else if (shift_now) begin
                rev_cnt_reg <= rev_cnt_reg + REV_W'(1);
            end
        end
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    a_step_advance: assert property (
        shift_now && stage_reg != STAGES_CLEAR
        |=> stage_reg != $past(stage_reg)
    ) else $error("ring did not advance on a step");

    a_clear_low: assert property (
        !clear_ok |=> stage_reg == STAGES_CLEAR ##1 stage_o == STAGES_CLEAR
    ) else $error("stages not low under clear");

    a_seed_bit: assert property (
        shift_now && stage_reg == STAGES_CLEAR |=> $onehot(stage_reg)
    ) else $error("empty ring was not seeded with one bit");

    a_fwd_recirc: assert property (
        shift_now && dir_reg && stage_reg[STAGES-1] |=> stage_reg[0]
    ) else $error("stage eight did not recirculate");

    a_rev_recirc: assert property (
        shift_now && !dir_reg && stage_reg[0] |=> stage_reg[STAGES-1]
    ) else $error("stage one did not recirculate");

    a_rev_shift: assert property (
        shift_now && !dir_reg
        |=> stage_reg[STAGES-2:0] == $past(stage_reg[STAGES-1:1])
    ) else $error("reverse shift wrong");

    a_data_map: assert property (
        mode_reg == MODE_WAVE && !step_en
        |=> phase_o.phase_data == $past(stage_reg[PHASES-1:0])
    ) else $error("phase data not stages one to four");

    a_enable_or: assert property (
        mode_reg == MODE_WAVE && !step_en
        |=> phase_o.phase_enable == $past(stage_reg[PHASES-1:0]
                                          | stage_reg[STAGES-1:PHASES])
    ) else $error("phase enable not the OR of stages four apart");

    a_wave_single: assert property (
        mode_reg == MODE_WAVE && $onehot(stage_reg) && !step_en
        |=> count_on(phase_o.phase_enable) == 1
    ) else $error("wave mode not one winding");

    a_normal_pair: assert property (
        mode_reg == MODE_NORMAL && $onehot(stage_reg) && !step_en
        |=> count_on(phase_o.phase_enable) == 2
    ) else $error("normal mode not two windings");

    a_half_alt: assert property (
        mode_reg == MODE_HALF && $onehot(stage_reg) && !step_en
        |=> count_on(phase_o.phase_enable)
            == ($past(half_reg) ? 2 : 1)
    ) else $error("half-step count wrong");

    a_rev_mark: assert property (
        shift_now && rev_cnt_reg == REV_LAST |=> rev_o ##1 !rev_o
    ) else $error("revolution marker missing");

    a_mode_steady: assert property (
        !step_en |=> mode_reg == $past(mode_reg)
    ) else $error("mode changed between steps");

    c_seed: cover property (
        shift_now && stage_reg == STAGES_CLEAR
    );

    c_reverse: cover property (
        shift_now && !dir_reg && stage_reg[0]
    );

    c_half: cover property (
        mode_reg == MODE_HALF && shift_now && half_reg
    );

    c_rev: cover property (rev_o);

endmodule : spsq_sequencer

// file: bench/spsq_bridge_model.sv
// behavioural half-bridge pairs and windings on the far side
`timescale 1ns/1ps
module spsq_bridge_model
    import spsq_pkg::*;
(
    // drive from the sequencer
    input wire spsq_phase_t phase_i,
    // winding state seen by the bench
    output logic [2:0] on_cnt_o,
    output logic [PHASES-1:0] pol_o
);
    // both bridges of one winding share its data and enable lines
    always_comb begin
        on_cnt_o = 3'h0;
        for (int i = 0; i < PHASES; i++) begin
            on_cnt_o = on_cnt_o + 3'(phase_i.phase_enable[i]);
        end
        // a disabled winding floats, so its polarity reads as zero
        pol_o = phase_i.phase_data & phase_i.phase_enable;
    end
endmodule : spsq_bridge_model

// file: bench/stepper_phase_sequencer_test.sv
// self-checking bench for the stepper phase sequencer
`timescale 1ns/1ps
module stepper_phase_sequencer_test;
    import spsq_pkg::*;
    // short step period keeps the run brief
    localparam int DIV = 8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic clr_n = 1'b0;
    logic dir = 1'b1;
    logic [2:0] mode = 3'h1;
    spsq_phase_t phase;
    logic [7:0] stage;
    logic step;
    logic rev;
    logic [2:0] on_cnt;
    logic [3:0] pol;
    logic [2:0] codes [5] = '{3'h1, 3'h2, 3'h3, 3'h0, 3'h5};
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    int revs = 0;
    int steps = 0;
    int seed = 96;
    int pos, m_mode, m_dir, shifts, prev;

    always #12.5 clk = ~clk;

    spsq_sequencer #(.STEP_DIV(DIV)) spsq_sequencer_inst (
        .core_clk_i(clk), .sys_rst_i(rst), .power_up_clear_n_i(clr_n),
        .dir_fwd_i(dir), .drive_mode_i(mode), .phase_o(phase),
        .stage_o(stage), .step_o(step), .rev_o(rev)
    );
    spsq_bridge_model spsq_bridge_model_inst (
        .phase_i(phase), .on_cnt_o(on_cnt), .pol_o(pol)
    );

    task close_out;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    always @(negedge clk) begin
        cycles++;
        if (rev === 1'b1) revs++;
        if (step === 1'b1) steps++;
        if (cycles == 3000) begin
            fail_count++;
            close_out();
        end
    end

    task check(string what, logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // energised positions: 0-3 one polarity, 4-7 reversed
    function automatic logic [7:0] exp_phase(int p, int md, int d);
        logic [7:0] e;
        e = 8'h01 << p;
        if (md == 2) e = e | (8'h01 << (d ? (p + 1) % 8 : (p + 7) % 8));
        return {e[3:0], e[3:0] | e[7:4]};
    endfunction : exp_phase

    task tick;
        repeat (DIV) @(negedge clk);
    endtask : tick

    task restart;
        clr_n = 1'b0; // clear held low well past the sync delay
        mode = 3'h1;
        dir = 1'b1;
        repeat (6) @(negedge clk);
        check("stage", stage, 8'h00);
        check("phase", phase, 8'h00);
        clr_n = 1'b1;
        for (int i = 0; i < 40 && stage === 8'h00; i++) @(negedge clk);
        // sample mid-period, well clear of the next step edge
        repeat (2) @(negedge clk);
        check("stage", stage, 8'h01);
        check("phase", phase, 8'h11);
        pos = 0;
        m_mode = 1;
        m_dir = 1;
        shifts = 1;
        revs = 0;
        steps = 0;
    endtask : restart

    task run_rand(int n);
        logic [7:0] e_ph;
        for (int k = 0; k < n; k++) begin
            mode = codes[$unsigned($random(seed)) % 5];
            dir = 1'($random(seed));
            tick();
            // illegal codes leave the old mode in force
            if (mode == 3'h1 || mode == 3'h2) m_mode = int'(mode);
            // the ring shifts the way the previous step chose; the new
            // direction only picks the neighbour from this step on
            pos = m_dir ? (pos + 1) % 8 : (pos + 7) % 8;
            m_dir = int'(dir);
            shifts++;
            e_ph = exp_phase(pos, m_mode, m_dir);
            check("stage", stage, 8'h01 << pos);
            check("phase", phase, e_ph);
            check("polarity", 8'(pol), 8'(e_ph[7:4] & e_ph[3:0]));
            check("windings", 8'(on_cnt), 8'(m_mode));
        end
    endtask : run_rand

    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check("phase", phase, 8'h00);
        restart();
        run_rand(70);
        check("revs", 8'(revs), 8'(shifts / 64));
        check("steps", 8'(steps), 8'(shifts - 1));
        restart();
        mode = 3'h4;
        tick();
        prev = int'(on_cnt);
        for (int k = 0; k < 12; k++) begin
            tick();
            check("half", 8'(int'(on_cnt) + prev), 8'h03);
            prev = int'(on_cnt);
        end
        close_out();
    end
endmodule : stepper_phase_sequencer_test
